// ==== common/vad_front_pkg.sv ====
// constants shared by the speech activity front end
package vad_front_pkg;
  localparam int          FRAME_MS            = 20;
  localparam int          SUBFRAME_MS         = 10;
  localparam int          SUBS_PER_FRAME      = FRAME_MS / SUBFRAME_MS;
  localparam int          SAMPLE_W            = 16;
  localparam int          PRE_W               = SAMPLE_W + 1;
  localparam int          COEF_FRAC           = 15;
  localparam int          COEF_W              = 17;
  localparam int          ACC_W               = 48;
  localparam int          BIN_W               = 24;
  localparam int          POW_W               = 64;
  localparam int          SUBCNT_W            = 16;
  localparam int          FIFO_DEPTH          = 8;
  localparam int          SUBFRAME_LEN        = 80;
  localparam int          PAD_OFFSET          = 24;
  localparam int          DFT_LEN             = 128;
  localparam logic [16:0] COEF_MAX            = 17'h07FFF;
  localparam logic [15:0] PRE_EMPH_FACTOR     = 16'h999A;
  localparam logic [15:0] ALPHA_CH_FIRST      = 16'h0000;
  localparam logic [15:0] ALPHA_CH_LATER      = 16'h399A;
  localparam logic [31:0] CH_ENERGY_SEED      = 32'h0000_0010;
  localparam logic [31:0] LT_SPEC_SEED        = 32'h0000_0100;
  localparam logic [31:0] NOISE_SEED          = 32'h0000_0010;
  localparam logic [7:0]  TONE_RATIO          = 8'h0A;
  localparam logic [15:0] SPEC_DEV_LIMIT_DEF  = 16'h0400;
endpackage

// ==== design/vad_front_end.sv ====
// sample fifo and pre-emphasis / zero-padded scaled transform front end
`timescale 1ns/1ns
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("sample_fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;
  logic [AW:0]   cnt_d;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// Overview of operation
// - Speech arrives in 20 ms frames, each split into two subframes.
// - One activity flag is given per frame for speech, music or tones.
// - Analysis runs once per 10 ms subframe, counted by a running counter.
// - Pre-emphasis memory is zero after initialization.
// - Channel energy, long-term spectrum and noise estimates start nonzero.
// - Each sample becomes input plus factor times the previous input.
// - Transform buffer: zeros below D and from L+D, samples in between.
// - Every bin of the M-point transform is computed, scaled by 2/M.
// - Tone flag: peak-to-average above 10 dB and deviation under its limit.
// - Energy smoothing factor is zero first, then 0.45 afterwards.
// - Frame flag is on when either subframe decision of the frame is on.
module vad_front_end
  import vad_front_pkg::*;
#(
  parameter int          L          = SUBFRAME_LEN,
  parameter int          D          = PAD_OFFSET,
  parameter int          M          = DFT_LEN,
  parameter int          FIFO_WORDS = FIFO_DEPTH,
  parameter logic [15:0] ZETA       = PRE_EMPH_FACTOR,
  parameter logic [15:0] DEV_LIMIT  = SPEC_DEV_LIMIT_DEF
) (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        SAMPLE_VALID,
  input  wire logic signed [SAMPLE_W-1:0]  SAMPLE_DATA,
  output      logic                        SAMPLE_READY,
  input  wire logic                        PITCH_GAIN_FLAG,
  input  wire logic [15:0]                 SPECTRAL_DEVIATION,
  input  wire logic                        SUB_DECISION_VALID,
  input  wire logic                        SUB_DECISION,
  output      logic                        BIN_VALID,
  output      logic [$clog2(M)-1:0]        BIN_INDEX,
  output      logic signed [BIN_W-1:0]     BIN_RE,
  output      logic signed [BIN_W-1:0]     BIN_IM,
  output      logic                        SUBFRAME_DONE,
  output      logic [SUBCNT_W-1:0]         SUBFRAME_COUNT,
  output      logic                        PITCH_GAIN_FLAG_OUT,
  output      logic                        TONE_FLAG,
  output      logic [15:0]                 ALPHA_CH,
  output      logic [31:0]                 CH_ENERGY_INIT,
  output      logic [31:0]                 LT_SPECTRUM_INIT,
  output      logic [31:0]                 NOISE_INIT,
  output      logic                        VAD_FLAG,
  output      logic                        FRAME_VALID
);
  localparam int PW = $clog2(M);
  localparam int QB = PW - 2;
  localparam int IW = $clog2(L + 1);
  localparam int SH = COEF_FRAC + PW - 1;

  generate
    if ((1 << PW) != M || M < 8 || L < 2 || L + D > M) begin : g_chk
      $error("vad_front_end needs power-of-two M of at least 8 and L + D <= M");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_FILL = 3'b001,
    ST_DFT  = 3'b010,
    ST_IDLE = 3'b100
  } state_t;

  typedef struct packed {
    state_t                          st;
    logic [SUBCNT_W-1:0]             sub_cnt;
    logic                            first;
    logic [IW-1:0]                   idx;
    logic [PW-1:0]                   bin;
    logic [PW-1:0]                   phase;
    logic [PW-1:0]                   base;
    logic signed [ACC_W-1:0]         acc_re;
    logic signed [ACC_W-1:0]         acc_im;
    logic signed [SAMPLE_W-1:0]      prev;
    logic [L-1:0][PRE_W-1:0]         buffer;
    logic [POW_W-1:0]                peak;
    logic [POW_W-1:0]                psum;
    logic                            bin_valid;
    logic [PW-1:0]                   bin_idx;
    logic signed [BIN_W-1:0]         bin_re;
    logic signed [BIN_W-1:0]         bin_im;
    logic                            done;
    logic                            pitch;
    logic                            tone;
    logic [15:0]                     alpha;
    logic [31:0]                     e_ch;
    logic [31:0]                     e_lt;
    logic [31:0]                     e_n;
    logic                            dec_half;
    logic                            dec_first;
    logic                            vad;
    logic                            frame_valid;
  } core_t;

  localparam core_t CORE_RST = '{
    st: ST_FILL, sub_cnt: '0, first: 1'b1, idx: '0, bin: '0, phase: '0, base: '0,
    acc_re: '0, acc_im: '0, prev: '0, buffer: '0, peak: '0, psum: '0,
    bin_valid: 1'b0, bin_idx: '0, bin_re: '0, bin_im: '0, done: 1'b0,
    pitch: 1'b0, tone: 1'b0, alpha: ALPHA_CH_FIRST, e_ch: CH_ENERGY_SEED,
    e_lt: LT_SPEC_SEED, e_n: NOISE_SEED, dec_half: 1'b0, dec_first: 1'b0,
    vad: 1'b0, frame_valid: 1'b0
  };

  // sine of 2*pi*p/M in Q15, cubic quarter-wave approximation
  function automatic logic signed [COEF_W-1:0] sin_q(input logic [PW-1:0] p);
    logic [63:0]       q;
    logic [63:0]       x;
    logic [63:0]       t;
    logic [COEF_W-1:0] mag;
    q = 64'(1) << QB;
    x = p[PW-2] ? (q - 64'(p[QB-1:0])) : 64'(p[QB-1:0]);
    t = ((x * (64'(3) * q * q - x * x)) << 14) >> (3 * QB);
    mag = (t > 64'(COEF_MAX)) ? COEF_MAX : t[COEF_W-1:0];
    sin_q = p[PW-1] ? -$signed(mag) : $signed(mag);
  endfunction

  logic                        fifo_valid;
  logic                        fifo_ready;
  logic signed [SAMPLE_W-1:0]  fifo_data;

  sample_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .in_data   (SAMPLE_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  core_t s_q;
  core_t s_d;

  assign fifo_ready = (s_q.st == ST_FILL);

  always_comb begin
    logic signed [PRE_W+15:0]    emph;
    logic signed [PRE_W-1:0]     pre;
    logic signed [PRE_W-1:0]     g;
    logic signed [COEF_W-1:0]    c;
    logic signed [COEF_W-1:0]    sn;
    logic signed [ACC_W-1:0]     sum_re;
    logic signed [ACC_W-1:0]     sum_im;
    logic signed [ACC_W-1:0]     sc_re;
    logic signed [ACC_W-1:0]     sc_im;
    logic [POW_W-1:0]            pw;
    logic [POW_W-1:0]            peak_n;
    logic [POW_W-1:0]            psum_n;
    emph   = '0;
    pre    = '0;
    g      = '0;
    c      = '0;
    sn     = '0;
    sum_re = '0;
    sum_im = '0;
    sc_re  = '0;
    sc_im  = '0;
    pw     = '0;
    peak_n = '0;
    psum_n = '0;
    s_d = s_q;
    s_d.bin_valid   = 1'b0;
    s_d.done        = 1'b0;
    s_d.frame_valid = 1'b0;
    case (s_q.st)
      ST_FILL: begin
        if (fifo_valid) begin
          emph = $signed(ZETA) * s_q.prev;
          pre  = PRE_W'(fifo_data) + PRE_W'(emph >>> COEF_FRAC);
          s_d.buffer[s_q.idx] = pre;
          s_d.prev = fifo_data;
          s_d.idx  = s_q.idx + 1'b1;
          if (s_q.idx == IW'(L - 1)) begin
            s_d.st     = ST_DFT;
            s_d.idx    = '0;
            s_d.bin    = '0;
            s_d.base   = '0;
            s_d.phase  = '0;
            s_d.acc_re = '0;
            s_d.acc_im = '0;
            s_d.peak   = '0;
            s_d.psum   = '0;
          end
        end
      end
      ST_DFT: begin
        // only D..L+D-1 are nonzero, so padded terms contribute nothing
        g  = $signed(s_q.buffer[s_q.idx]);
        c  = sin_q(s_q.phase + PW'(M / 4));
        sn = sin_q(s_q.phase);
        sum_re = s_q.acc_re + ACC_W'(g * c);
        sum_im = s_q.acc_im - ACC_W'(g * sn);
        s_d.acc_re = sum_re;
        s_d.acc_im = sum_im;
        s_d.idx    = s_q.idx + 1'b1;
        s_d.phase  = s_q.phase + s_q.bin;
        if (s_q.idx == IW'(L - 1)) begin
          sc_re = sum_re >>> SH;
          sc_im = sum_im >>> SH;
          s_d.bin_valid = 1'b1;
          s_d.bin_idx   = s_q.bin;
          s_d.bin_re    = sc_re[BIN_W-1:0];
          s_d.bin_im    = sc_im[BIN_W-1:0];
          pw = POW_W'(sc_re * sc_re) + POW_W'(sc_im * sc_im);
          peak_n = s_q.peak;
          psum_n = s_q.psum;
          if (s_q.bin < PW'(M / 2)) begin
            psum_n = s_q.psum + pw;
            if (s_q.bin >= PW'(2) && pw > s_q.peak) begin
              peak_n = pw;
            end
          end
          s_d.peak   = peak_n;
          s_d.psum   = psum_n;
          s_d.acc_re = '0;
          s_d.acc_im = '0;
          s_d.idx    = '0;
          s_d.bin    = s_q.bin + 1'b1;
          s_d.base   = s_q.base + PW'(D);
          s_d.phase  = s_q.base + PW'(D);
          if (s_q.bin == PW'(M - 1)) begin
            s_d.st      = ST_IDLE;
            s_d.done    = 1'b1;
            s_d.sub_cnt = s_q.sub_cnt + 1'b1;
            s_d.pitch   = PITCH_GAIN_FLAG;
            s_d.tone    = ((peak_n * POW_W'(M / 2)) > (psum_n * POW_W'(TONE_RATIO)))
                          && (SPECTRAL_DEVIATION < DEV_LIMIT);
            s_d.alpha   = s_q.first ? ALPHA_CH_FIRST : ALPHA_CH_LATER;
            s_d.first   = 1'b0;
          end
        end
      end
      ST_IDLE: begin
        s_d.st = ST_FILL;
      end
      default: begin
        s_d.st = ST_FILL;
      end
    endcase
    if (SUB_DECISION_VALID) begin
      s_d.dec_half = ~s_q.dec_half;
      if (s_q.dec_half) begin
        s_d.vad         = s_q.dec_first | SUB_DECISION;
        s_d.frame_valid = 1'b1;
      end else begin
        s_d.dec_first = SUB_DECISION;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign BIN_VALID           = s_q.bin_valid;
  assign BIN_INDEX           = s_q.bin_idx;
  assign BIN_RE              = s_q.bin_re;
  assign BIN_IM              = s_q.bin_im;
  assign SUBFRAME_DONE       = s_q.done;
  assign SUBFRAME_COUNT      = s_q.sub_cnt;
  assign PITCH_GAIN_FLAG_OUT = s_q.pitch;
  assign TONE_FLAG           = s_q.tone;
  assign ALPHA_CH            = s_q.alpha;
  assign CH_ENERGY_INIT      = s_q.e_ch;
  assign LT_SPECTRUM_INIT    = s_q.e_lt;
  assign NOISE_INIT          = s_q.e_n;
  assign VAD_FLAG            = s_q.vad;
  assign FRAME_VALID         = s_q.frame_valid;
endmodule

// ==== testbench/speech_encoder_model.sv ====
// encoder model feeding filtered speech samples and the pitch flag
`timescale 1ns/1ns
module speech_encoder_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        kind,
  input  wire logic        pitch,
  input  wire logic [1:0]  gap,
  input  wire logic        ready,
  output      logic        valid,
  output      logic [15:0] data,
  output      logic        pitch_flag,
  output      logic        busy
);
  assign pitch_flag = pitch;
  initial begin
    valid = 1'b0;
    data  = 16'h5A5A;
    busy  = 1'b0;
  end
  // one subframe of samples, held until taken
  always @(posedge go) begin
    busy = 1'b1;
    for (int n = 0; n < 80; n++) begin
      if (gap != 2'h0) begin
        valid = 1'b0;
        data  = ~data;
        repeat (gap) @(posedge clk);
        #1;
      end
      valid = 1'b1;
      data  = (kind && n[1]) ? -16'sh0FA0 : 16'sh0FA0;
      @(posedge clk);
      while (!ready) @(posedge clk);
      #1;
    end
    valid = 1'b0;
    data  = ~data;
    busy  = 1'b0;
  end
endmodule

// ==== testbench/vad_front_end_assertions.sv ====
// concurrent checks on the front end ports
`timescale 1ns/1ns
module vad_front_end_checker
  import vad_front_pkg::*;
#(
  parameter int          M         = DFT_LEN,
  parameter logic [15:0] DEV_LIMIT = SPEC_DEV_LIMIT_DEF
) (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic                 PITCH_GAIN_FLAG,
  input wire logic [15:0]          SPECTRAL_DEVIATION,
  input wire logic                 SUB_DECISION_VALID,
  input wire logic                 SUB_DECISION,
  input wire logic                 BIN_VALID,
  input wire logic [$clog2(M)-1:0] BIN_INDEX,
  input wire logic                 SUBFRAME_DONE,
  input wire logic [SUBCNT_W-1:0]  SUBFRAME_COUNT,
  input wire logic                 PITCH_GAIN_FLAG_OUT,
  input wire logic                 TONE_FLAG,
  input wire logic [15:0]          ALPHA_CH,
  input wire logic                 VAD_FLAG,
  input wire logic                 FRAME_VALID
);
  logic half_q;
  logic first_q;
  // pairing of subframe decisions
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      half_q  <= 1'b0;
      first_q <= 1'b0;
    end else if (SUB_DECISION_VALID) begin
      half_q  <= !half_q;
      first_q <= SUB_DECISION;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_done_last_bin: assert property (SUBFRAME_DONE == (BIN_VALID && BIN_INDEX == M - 1))
    else $error("done not with last bin");
  a_bin_step: assert property (BIN_VALID && BIN_INDEX != M - 1 |->
    ##80 BIN_VALID && BIN_INDEX == $past(BIN_INDEX, 80) + 1) else $error("bin step");
  a_count_step: assert property (SUBFRAME_DONE |->
    SUBFRAME_COUNT == $past(SUBFRAME_COUNT) + 1'b1) else $error("count step");
  a_quiet_hold: assert property (!SUBFRAME_DONE |-> $stable(SUBFRAME_COUNT) &&
    $stable(ALPHA_CH) && $stable(TONE_FLAG)) else $error("status moved");
  a_alpha_step: assert property (SUBFRAME_DONE |-> ALPHA_CH ==
    ($past(SUBFRAME_COUNT) == 0 ? ALPHA_CH_FIRST : ALPHA_CH_LATER)) else $error("alpha");
  a_pitch_take: assert property (SUBFRAME_DONE |->
    PITCH_GAIN_FLAG_OUT == $past(PITCH_GAIN_FLAG)) else $error("pitch flag");
  a_tone_block: assert property (SUBFRAME_DONE && $past(SPECTRAL_DEVIATION) >= DEV_LIMIT
    |-> !TONE_FLAG) else $error("tone not blocked");
  a_frame_pair: assert property (SUB_DECISION_VALID && half_q |=> FRAME_VALID &&
    VAD_FLAG == ($past(first_q) | $past(SUB_DECISION))) else $error("frame flag");
  a_frame_quiet: assert property (!(SUB_DECISION_VALID && half_q) |=>
    !FRAME_VALID && $stable(VAD_FLAG)) else $error("frame flag moved");
  c_subframe: cover property (SUBFRAME_DONE);
  c_tone: cover property (SUBFRAME_DONE ##1 TONE_FLAG);
  c_frame_on: cover property (FRAME_VALID && VAD_FLAG);
endmodule
bind vad_front_end vad_front_end_checker #(.M(M), .DEV_LIMIT(DEV_LIMIT)) i_vad_front_end_checker (
  .CLK(CLK), .RST_N(RST_N), .PITCH_GAIN_FLAG(PITCH_GAIN_FLAG),
  .SPECTRAL_DEVIATION(SPECTRAL_DEVIATION), .SUB_DECISION_VALID(SUB_DECISION_VALID),
  .SUB_DECISION(SUB_DECISION), .BIN_VALID(BIN_VALID), .BIN_INDEX(BIN_INDEX),
  .SUBFRAME_DONE(SUBFRAME_DONE), .SUBFRAME_COUNT(SUBFRAME_COUNT),
  .PITCH_GAIN_FLAG_OUT(PITCH_GAIN_FLAG_OUT), .TONE_FLAG(TONE_FLAG), .ALPHA_CH(ALPHA_CH),
  .VAD_FLAG(VAD_FLAG), .FRAME_VALID(FRAME_VALID));

// ==== testbench/tb_vad_front_end.sv ====
// self-checking bench for the speech activity front end
`timescale 1ns/1ns
module tb_vad_front_end
  import vad_front_pkg::*;
;
  logic               CLK, RST_N, SAMPLE_VALID, SAMPLE_READY, PITCH_GAIN_FLAG, BIN_VALID;
  logic               SUB_DECISION_VALID, SUB_DECISION, SUBFRAME_DONE, PITCH_GAIN_FLAG_OUT;
  logic               TONE_FLAG, VAD_FLAG, FRAME_VALID, go, kind, pitch_lvl, busy;
  logic signed [15:0] SAMPLE_DATA;
  logic signed [23:0] BIN_RE, BIN_IM;
  logic [15:0]        SPECTRAL_DEVIATION, ALPHA_CH, SUBFRAME_COUNT;
  logic [31:0]        CH_ENERGY_INIT, LT_SPECTRUM_INIT, NOISE_INIT;
  logic [6:0]         BIN_INDEX;
  logic [1:0]         gap;
  int                 miscompares = 0, n_checks = 0, cyc = 0, nsent = 0, bin_k = 0, xprev = 0;
  int                 sub_k = 0;
  real                er[2][128], ei[2][128], etol[2];
  bit                 et[2];
  vad_front_end i_vad_front_end (.CLK(CLK), .RST_N(RST_N), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_READY(SAMPLE_READY), .PITCH_GAIN_FLAG(PITCH_GAIN_FLAG),
    .SPECTRAL_DEVIATION(SPECTRAL_DEVIATION), .SUB_DECISION_VALID(SUB_DECISION_VALID),
    .SUB_DECISION(SUB_DECISION), .BIN_VALID(BIN_VALID), .BIN_INDEX(BIN_INDEX), .BIN_RE(BIN_RE),
    .BIN_IM(BIN_IM), .SUBFRAME_DONE(SUBFRAME_DONE), .SUBFRAME_COUNT(SUBFRAME_COUNT),
    .PITCH_GAIN_FLAG_OUT(PITCH_GAIN_FLAG_OUT), .TONE_FLAG(TONE_FLAG), .ALPHA_CH(ALPHA_CH),
    .CH_ENERGY_INIT(CH_ENERGY_INIT), .LT_SPECTRUM_INIT(LT_SPECTRUM_INIT),
    .NOISE_INIT(NOISE_INIT), .VAD_FLAG(VAD_FLAG), .FRAME_VALID(FRAME_VALID));
  speech_encoder_model i_speech_encoder_model (.clk(CLK), .go(go), .kind(kind),
    .pitch(pitch_lvl), .gap(gap), .ready(SAMPLE_READY), .valid(SAMPLE_VALID),
    .data(SAMPLE_DATA), .pitch_flag(PITCH_GAIN_FLAG), .busy(busy));
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] ex);
    n_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic chk_r(string nm, real ex, logic signed [23:0] got, real tol);
    n_checks++;
    if ($isunknown(got) || ex - got > tol || got - ex > tol) begin
      miscompares++;
      $display("ERROR %s expected %0.1f seen %0d", nm, ex, got);
    end
  endtask
  // reference bins and tone decision of one subframe
  function automatic void predict(int b, bit k);
    int x, d[80];
    real re, im, a, sa, pk, sm, p;
    sa = 0;
    pk = 0;
    sm = 0;
    for (int n = 0; n < SUBFRAME_LEN; n++) begin
      x = (k && n[1]) ? -16'sh0FA0 : 16'sh0FA0;
      d[n] = x + ((xprev * $signed(PRE_EMPH_FACTOR)) >>> COEF_FRAC);
      xprev = x;
      sa += (d[n] < 0) ? -d[n] : d[n];
    end
    for (int q = 0; q < DFT_LEN; q++) begin
      re = 0;
      im = 0;
      for (int n = 0; n < SUBFRAME_LEN; n++) begin
        a = 6.283185307179586 * q * (n + PAD_OFFSET) / DFT_LEN;
        re += d[n] * $cos(a);
        im -= d[n] * $sin(a);
      end
      er[b][q] = re * 2 / DFT_LEN;
      ei[b][q] = im * 2 / DFT_LEN;
      p = er[b][q] * er[b][q] + ei[b][q] * ei[b][q];
      if (q < 64) sm += p;
      if (q >= 2 && q < 64 && p > pk) pk = p;
    end
    et[b] = pk * 64 > 10 * sm;
    etol[b] = 0.05 * sa * 2 / DFT_LEN + 4;
  endfunction
  always @(negedge CLK) begin
    if (RST_N === 1'b1 && BIN_VALID === 1'b1) begin
      chk("BIN_INDEX", BIN_INDEX, bin_k);
      chk("SUBFRAME_DONE", SUBFRAME_DONE, bin_k == DFT_LEN - 1);
      chk_r("BIN_RE", er[sub_k % 2][bin_k], BIN_RE, etol[sub_k % 2]);
      chk_r("BIN_IM", ei[sub_k % 2][bin_k], BIN_IM, etol[sub_k % 2]);
      bin_k = (bin_k + 1) % DFT_LEN;
      if (bin_k == 0) sub_k++;
    end
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic send_sub(bit k, logic [1:0] g);
    predict(nsent % 2, k);
    nsent++;
    @(posedge CLK);
    #1 kind = k;
    gap = g;
    go = 1'b1;
    @(posedge CLK);
    #1 go = 1'b0;
  endtask
  task automatic wait_done(bit pit, logic [15:0] dev, int b);
    int w;
    pitch_lvl = pit;
    SPECTRAL_DEVIATION = dev;
    w = 0;
    while (SUBFRAME_DONE !== 1'b1 && w < 12000) begin
      @(posedge CLK);
      #1;
      w++;
    end
    chk("SUBFRAME_COUNT", SUBFRAME_COUNT, b + 1);
    chk("ALPHA_CH", ALPHA_CH, b == 0 ? ALPHA_CH_FIRST : ALPHA_CH_LATER);
    chk("PITCH_GAIN_FLAG_OUT", PITCH_GAIN_FLAG_OUT, pit);
    chk("TONE_FLAG", TONE_FLAG, et[b % 2] && dev < SPEC_DEV_LIMIT_DEF);
    @(posedge CLK);
    #1;
  endtask
  task automatic t_reset_state();
    chk("SAMPLE_READY", SAMPLE_READY, 1'b1);
    chk("VAD_FLAG", VAD_FLAG, 1'b0);
    chk("CH_ENERGY_INIT", CH_ENERGY_INIT, CH_ENERGY_SEED);
    chk("LT_SPECTRUM_INIT", LT_SPECTRUM_INIT, LT_SPEC_SEED);
    chk("NOISE_INIT", NOISE_INIT, NOISE_SEED);
  endtask
  task automatic t_decisions();
    for (int i = 1; i < 5; i++) begin
      @(posedge CLK);
      #1 SUB_DECISION_VALID = 1'b1;
      SUB_DECISION = i[0];
      @(posedge CLK);
      #1 SUB_DECISION_VALID = 1'b0;
      chk("FRAME_VALID", FRAME_VALID, 1'b0);
      repeat (2) @(posedge CLK);
      #1 SUB_DECISION_VALID = 1'b1;
      SUB_DECISION = i[1];
      @(posedge CLK);
      #1 SUB_DECISION_VALID = 1'b0;
      chk("FRAME_VALID", FRAME_VALID, 1'b1);
      chk("VAD_FLAG", VAD_FLAG, i[0] | i[1]);
    end
  endtask
  task automatic t_tone_refill();
    int w;
    send_sub(1'b1, 2'h0);
    w = 0;
    while (busy && w < 500) begin
      @(posedge CLK);
      w++;
    end
    send_sub(1'b1, 2'h0);
    repeat (30) @(posedge CLK);
    #1 chk("SAMPLE_READY", SAMPLE_READY, 1'b0);
    wait_done(1'b0, 16'h0000, 1);
    wait_done(1'b1, SPEC_DEV_LIMIT_DEF, 2);
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    RST_N = 1'b0;
    {go, kind, pitch_lvl, gap, SUB_DECISION_VALID, SUB_DECISION} = '0;
    SPECTRAL_DEVIATION = 16'h0000;
    repeat (20) @(posedge CLK);
    #1 RST_N = 1'b1;
    t_reset_state();
    t_decisions();
    send_sub(1'b0, 2'h2);
    wait_done(1'b1, 16'h0000, 0);
    t_tone_refill();
    wrap_up();
  end
endmodule
